// ---- rtl/slsf_defines.vh ----
// slsf_defines.vh - offsets, field positions, reset values and codes for the
// sample format register slice.
// assumes byte-wide registers on a plain address/strobe port.
`ifndef SLSF_DEFINES_VH
`define SLSF_DEFINES_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define SLSF_ADDR_W          12
`define SLSF_OFS_CTRL_RES    12'h58f
`define SLSF_OFS_SUBCL_NP    12'h590
`define SLSF_OFS_SPF         12'h591
`define SLSF_OFS_HD_CF       12'h592

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SLSF_CS_HI           7
`define SLSF_CS_LO           6
`define SLSF_RES_HI          4
`define SLSF_RES_LO          0
`define SLSF_SC_HI           7
`define SLSF_SC_LO           5
`define SLSF_NP_HI           4
`define SLSF_NP_LO           0
`define SLSF_HD_BIT          7

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SLSF_RST_CS          2'h0
`define SLSF_RST_RES         5'h0f
`define SLSF_RST_SC          3'h1
`define SLSF_RST_NP          5'h0f
`define SLSF_RST_SPF_TOP     3'h1
`define SLSF_RST_SPF         5'h00

// ----------------------------------------------------------------------
// codes
// ----------------------------------------------------------------------
`define SLSF_CS_NONE         2'h0
`define SLSF_CS_ONE          2'h1
`define SLSF_CS_TWO          2'h2
`define SLSF_CS_THREE        2'h3
`define SLSF_RES_MIN         5'h06
`define SLSF_RES_MAX         5'h0f
`define SLSF_NP_8            5'h07
`define SLSF_NP_12           5'h0b
`define SLSF_NP_16           5'h0f
`define SLSF_SC_0            3'h0
`define SLSF_SC_1            3'h1

`endif

// ---- rtl/slsf_sync3.v ----
// slsf_sync3.v - three-stage synchroniser for a level from outside clk_sys.
// assumes the input is a slow status level; output changes once stages 2 and 3 agree.
`timescale 1ns/1ps

module slsf_sync3 (
  // clock and reset
  input  wire clk_sys,
  input  wire reset,
  // level in and filtered out
  input  wire din,
  output reg  dout
);

  reg s1;
  reg s2;
  reg s3;

  // ----------------------------------------------------------------------
  // chain; stage 1 feeds only stage 2 to keep metastability contained
  // ----------------------------------------------------------------------
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s1   <= 1'b0;
      s2   <= 1'b0;
      s3   <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end

endmodule

// ---- rtl/slsf_regs.v ----
// slsf_regs.v - sample format register slice for the serial link framer.
// assumes a byte register port on clk_sys; framer parameters come from
// framer logic on the same clock, the density strap from a pin.
//
// Operation
// - control-bit count code 1,2,3 selects bit2; bits2,1; bits2,1,0
// - resolution field holds resolution minus one, codes 6..15, resets to 0xf
// - bits-per-sample accepts codes 7, 11, 15 only; resets to 0xf
// - samples-per-frame field is read-only, parameter minus one, resets to zero
// - read-only density flag reads 1 when high-density packing is enabled
// - control-bit count zero means no control bits with each sample
`timescale 1ns/1ps
`include "slsf_defines.vh"

module slsf_regs (
  // clock and reset
  input  wire                      clk_sys,
  input  wire                      reset,
  // register port
  input  wire [`SLSF_ADDR_W-1:0]   reg_addr,
  input  wire [7:0]                reg_wdata,
  input  wire                      reg_wr,
  input  wire                      reg_rd,
  output reg  [7:0]                reg_rdata,
  // framer status in
  input  wire [4:0]                spf_minus_one,
  input  wire [4:0]                ctrl_words_per_frame,
  input  wire                      hd_enable_pin,
  // decoded configuration out
  output reg  [1:0]                cs_count,
  output reg  [2:0]                cs_bit_mask,
  output reg  [4:0]                resolution_bits,
  output reg  [4:0]                sample_bits,
  output reg                       subclass_one
);

  // field registers
  reg  [1:0] cs_code;
  reg  [4:0] res_code;
  reg  [2:0] sc_code;
  reg  [4:0] np_code;
  reg  [4:0] spf_code;
  reg  [4:0] cf_code;
  wire       hd_flag;
  // address hits and gated write strobes
  wire       hit_ctrl_res;
  wire       hit_subcl_np;
  wire       wr_ctrl_res;
  wire       wr_subcl_np;
  // next values
  reg  [1:0] next_cs_code;
  reg  [4:0] next_res_code;
  reg  [2:0] next_sc_code;
  reg  [4:0] next_np;
  reg  [2:0] next_mask;
  reg  [4:0] next_resolution;
  reg  [4:0] next_sample;
  reg        next_subclass;
  reg  [7:0] next_rdata;

  // ----------------------------------------------------------------------
  // density strap from a pin
  // ----------------------------------------------------------------------
  slsf_sync3 u_hd_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .din     (hd_enable_pin),
    .dout    (hd_flag)
  );

  // ----------------------------------------------------------------------
  // address decode for the write path
  // ----------------------------------------------------------------------
  assign hit_ctrl_res = (reg_addr == `SLSF_OFS_CTRL_RES);
  assign hit_subcl_np = (reg_addr == `SLSF_OFS_SUBCL_NP);

  // read-only and unmapped offsets raise neither strobe, so such writes vanish
  assign wr_ctrl_res  = reg_wr & hit_ctrl_res;
  assign wr_subcl_np  = reg_wr & hit_subcl_np;

  // ----------------------------------------------------------------------
  // writable fields
  // ----------------------------------------------------------------------
  // next values; a field this write does not address keeps its value
  always @* begin
    next_cs_code  = cs_code;
    next_res_code = res_code;
    next_sc_code  = sc_code;
    if (wr_ctrl_res) begin
      next_cs_code  = reg_wdata[`SLSF_CS_HI:`SLSF_CS_LO];
      next_res_code = reg_wdata[`SLSF_RES_HI:`SLSF_RES_LO];
    end
    if (wr_subcl_np) begin
      next_sc_code  = reg_wdata[`SLSF_SC_HI:`SLSF_SC_LO];
    end
  end

  // bits-per-sample: unsupported codes are dropped, the old value stays;
  // subclass bits of the same write are still taken
  always @* begin
    next_np = np_code;
    if (wr_subcl_np) begin
      case (reg_wdata[`SLSF_NP_HI:`SLSF_NP_LO])
        `SLSF_NP_8, `SLSF_NP_12, `SLSF_NP_16: begin
          next_np = reg_wdata[`SLSF_NP_HI:`SLSF_NP_LO];
        end
        default: begin
          next_np = np_code;
        end
      endcase
    end
  end

  // field flops; resolution codes outside 6..15 are kept as written
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cs_code  <= `SLSF_RST_CS;
      res_code <= `SLSF_RST_RES;
      sc_code  <= `SLSF_RST_SC;
      np_code  <= `SLSF_RST_NP;
    end else begin
      cs_code  <= next_cs_code;
      res_code <= next_res_code;
      sc_code  <= next_sc_code;
      np_code  <= next_np;
    end
  end

  // ----------------------------------------------------------------------
  // read-only framer parameters, captured so reads stay stable
  // ----------------------------------------------------------------------
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      spf_code <= `SLSF_RST_SPF;
      cf_code  <= 5'h00;
    end else begin
      spf_code <= spf_minus_one;
      cf_code  <= ctrl_words_per_frame;
    end
  end

  // ----------------------------------------------------------------------
  // control-bit decode
  // ----------------------------------------------------------------------
  always @* begin
    case (cs_code)
      `SLSF_CS_NONE: begin
        next_mask = 3'h0;
      end
      `SLSF_CS_ONE: begin
        next_mask = 3'h4;
      end
      `SLSF_CS_TWO: begin
        next_mask = 3'h6;
      end
      `SLSF_CS_THREE: begin
        next_mask = 3'h7;
      end
      default: begin
        next_mask = 3'h0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // width decodes; both fields hold the width minus one
  // ----------------------------------------------------------------------
  // five bits carry 16, the widest setting, without wrapping
  always @* begin
    next_resolution = res_code + 5'h01;
    next_sample     = np_code + 5'h01;
    next_subclass   = (sc_code == `SLSF_SC_1);
  end

  // ----------------------------------------------------------------------
  // registered outputs toward the framer
  // ----------------------------------------------------------------------
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cs_count        <= `SLSF_RST_CS;
      cs_bit_mask     <= 3'h0;
      resolution_bits <= 5'h10;
      sample_bits     <= 5'h10;
      subclass_one    <= 1'b1;
    end else begin
      cs_count        <= cs_code;
      cs_bit_mask     <= next_mask;
      resolution_bits <= next_resolution;
      sample_bits     <= next_sample;
      subclass_one    <= next_subclass;
    end
  end

  // ----------------------------------------------------------------------
  // read mux; unmapped addresses read zero
  // ----------------------------------------------------------------------
  always @* begin
    case (reg_addr)
      `SLSF_OFS_CTRL_RES: begin
        next_rdata = {cs_code, 1'b0, res_code};
      end
      `SLSF_OFS_SUBCL_NP: begin
        next_rdata = {sc_code, np_code};
      end
      `SLSF_OFS_SPF: begin
        next_rdata = {`SLSF_RST_SPF_TOP, spf_code};
      end
      `SLSF_OFS_HD_CF: begin
        next_rdata = {hd_flag, 2'h0, cf_code};
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // data stands only in the cycle after the read strobe
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

// ---- dv/slsf_regs_assertions.sv ----
// slsf_regs_assertions.sv - port checks for the sample format slice
// assumes decoded outputs follow a write two edges later
`timescale 1ns/1ps
module slsf_chk (
  // clock and reset
  input wire        clk_sys,
  input wire        reset,
  // register port
  input wire [11:0] reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata,
  // framer side and decoded outputs
  input wire [4:0]  spf_minus_one,
  input wire        hd_enable_pin,
  input wire [2:0]  cs_bit_mask,
  input wire [4:0]  resolution_bits,
  input wire [4:0]  sample_bits,
  input wire        subclass_one
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ------------------------------------------------------------
  // write decode helpers
  // ------------------------------------------------------------
  wire w_cr  = reg_wr && reg_addr == 12'h58f;
  wire w_sn  = reg_wr && reg_addr == 12'h590;
  wire np_ok = reg_wdata[4:0] == 5'h07 || reg_wdata[4:0] == 5'h0b || reg_wdata[4:0] == 5'h0f;
  // synchroniser lag means the pin must sit still before a read
  sequence s_hd_steady;
    $stable(hd_enable_pin) [*8];
  endsequence
  a_mask_decode: assert property (w_cr && reg_wdata[7:6] != 2'h0 |-> ##2
    cs_bit_mask == {1'b1, $past(reg_wdata[7], 2), &$past(reg_wdata[7:6], 2)}) else $error("mask decode");
  a_no_ctrl: assert property (w_cr && reg_wdata[7:6] == 2'h0 |-> ##2 cs_bit_mask == 3'h0)
    else $error("mask not empty");
  a_res_plus_one: assert property (w_cr |-> ##2 resolution_bits == $past(reg_wdata[4:0], 2) + 5'h01)
    else $error("resolution decode");
  a_np_taken: assert property (w_sn && np_ok |-> ##2 sample_bits == $past(reg_wdata[4:0], 2) + 5'h01)
    else $error("sample bits decode");
  a_np_refused: assert property (w_sn && !np_ok |=> ##1 $stable(sample_bits))
    else $error("bad sample code taken");
  a_subclass_sel: assert property (w_sn |-> ##2 subclass_one == ($past(reg_wdata[7:5], 2) == 3'h1))
    else $error("subclass decode");
  a_spf_read: assert property (reg_rd && reg_addr == 12'h591 && $stable(spf_minus_one) && !$past(reset) |=>
    reg_rdata == {3'h1, $past(spf_minus_one)}) else $error("spf readback");
  a_hd_read: assert property (s_hd_steady ##0 (reg_rd && reg_addr == 12'h592) |=>
    reg_rdata[7] == $past(hd_enable_pin)) else $error("hd readback");
endmodule

bind slsf_regs slsf_chk u_chk (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .spf_minus_one(spf_minus_one),
  .hd_enable_pin(hd_enable_pin), .cs_bit_mask(cs_bit_mask), .resolution_bits(resolution_bits),
  .sample_bits(sample_bits), .subclass_one(subclass_one));

// ---- dv/tb.sv ----
// tb.sv - register-port tests for the sample format slice
// assumes byte reads answer one cycle after the strobe
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  reg        clk_sys = 0, reset = 1, reg_wr = 0, reg_rd = 0, hd_enable_pin = 0;
  reg [11:0] reg_addr = 0;
  reg [7:0]  reg_wdata = 0;
  reg [4:0]  spf_minus_one = 5'h03, ctrl_words_per_frame = 5'h00, rc, np_exp = 5'h0f;
  reg [2:0]  m;
  wire [7:0] reg_rdata;
  wire [1:0] cs_count;
  wire [2:0] cs_bit_mask;
  wire [4:0] resolution_bits, sample_bits;
  wire       subclass_one;
  int        fail_count = 0, n_checks = 0, cyc = 0, i;
  reg [4:0]  npc [4] = '{5'h07, 5'h0b, 5'h0f, 5'h05};
  always #2 clk_sys = ~clk_sys;
  slsf_regs u_slsf_regs (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .spf_minus_one(spf_minus_one),
    .ctrl_words_per_frame(ctrl_words_per_frame), .hd_enable_pin(hd_enable_pin), .cs_count(cs_count),
    .cs_bit_mask(cs_bit_mask), .resolution_bits(resolution_bits), .sample_bits(sample_bits),
    .subclass_one(subclass_one));
  // ------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------
  task automatic wr(input [11:0] a, input [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic rd(input [11:0] a, input [7:0] e);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask
  task automatic outs(input [1:0] cc, input [2:0] mk, input [4:0] r, input [4:0] s, input sc);
    `CHK(cs_count, cc)
    `CHK(cs_bit_mask, mk)
    `CHK(resolution_bits, r)
    `CHK(sample_bits, s)
    `CHK(subclass_one, sc)
  endtask
  task automatic results;
    $display("checks=%0d fail_count=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // hang guard, tests need about 110 cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    rd(12'h58f, 8'h0f);
    rd(12'h590, 8'h2f);
    rd(12'h591, 8'h23);
    outs(2'h0, 3'h0, 5'h10, 5'h10, 1'b1);
    $display("test reset_values done");
    // each control-bit code, resolution at both ends of its range
    for (i = 0; i < 4; i++) begin
      rc = 5'h06 + i[4:0] * 5'h03;
      m = {i != 0, i > 1, i == 3};
      // reserved bit 5 written high must read back low
      wr(12'h58f, {i[1:0], 1'b1, rc});
      outs(i[1:0], m, rc + 5'h01, 5'h10, 1'b1);
      rd(12'h58f, {i[1:0], 1'b0, rc});
    end
    $display("test ctrl_bits done");
    // sample codes with alternating subclass, unsupported code last
    for (i = 0; i < 4; i++) begin
      wr(12'h590, {2'h0, i[0], npc[i]});
      if (i < 3) np_exp = npc[i];
      outs(2'h3, m, rc + 5'h01, np_exp + 5'h01, i[0]);
      rd(12'h590, {2'h0, i[0], np_exp});
    end
    $display("test sample_bits done");
    // read-only and unmapped writes change nothing
    wr(12'h591, 8'hff);
    wr(12'h592, 8'hff);
    wr(12'h5a0, 8'hff);
    outs(2'h3, 3'h7, 5'h10, 5'h10, 1'b1);
    rd(12'h58f, 8'hcf);
    rd(12'h590, 8'h2f);
    rd(12'h591, 8'h23);
    rd(12'h592, 8'h00);
    @(posedge clk_sys);
    spf_minus_one <= 5'h1f;
    ctrl_words_per_frame <= 5'h05;
    hd_enable_pin <= 1'b1;
    repeat (10) @(posedge clk_sys);
    rd(12'h591, 8'h3f);
    rd(12'h592, 8'h85);
    @(posedge clk_sys);
    hd_enable_pin <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rd(12'h592, 8'h05);
    $display("test read_only done");
    // reset again mid-run; a read raised with the release sees the cleared capture
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset    <= 1'b0;
    reg_rd   <= 1'b1;
    reg_addr <= 12'h591;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, 8'h20)
    outs(2'h0, 3'h0, 5'h10, 5'h10, 1'b1);
    rd(12'h58f, 8'h0f);
    rd(12'h590, 8'h2f);
    $display("test reset_again done");
    results();
  end
endmodule
